// File: logic/gp_pin_function_status.sv
/*
 gp_pin_function_status.sv: function selection and status lines for the
 nine general-purpose pins. Assumes usb core strobes and spi engine
 levels are synchronous to clk, and that pins 0 and 1 own no dedicated
 function, so the dedicated role only floats them.
*/
// Operation
// RULE_01 - nine pins, each gpio, select or function
// RULE_02 - reads see all pins, writes hit outputs
// RULE_03 - select pins driven with engine idle/active levels
// RULE_04 - suspend line low in suspend, high resumed
// RULE_05 - configured line high at reset, low configured
// RULE_06 - suspend signalling enters suspend, indicators follow
// RULE_07 - resume, bus reset or device reset resume
// RULE_08 - over 3 ms without traffic means suspend
// RULE_09 - low power line flags unconfigured device
// RULE_10 - event input pin is sampled and counted
// RULE_11 - external master requests bus on request line
// RULE_12 - ack line shows bus actually released
// RULE_13 - led line shows transfer in progress
// RULE_14 - led low while active, high idle
// RULE_15 - release at once if idle, else after transfer
// RULE_16 - low power line low at reset, high configured
// RULE_17 - request is active low, device evaluates it
// RULE_18 - unassigned functions leave other pins alone
`timescale 1ns/1ps
`include "gp_pin_consts.svh"
module gp_pin_function_status
  import gp_pin_pkg::*;
#(
  parameter int IDLE_SUSPEND_CYCLES = `IDLE_SUSPEND_CYCLES,
  parameter int COUNT_WIDTH = `EVENT_COUNT_WIDTH
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire pin_role_e [`GP_PIN_COUNT-1:0] pin_role,
  input wire gpio_write_s gpio_write,
  input wire usb_events_s usb_events,
  input wire logic [`GP_PIN_COUNT-1:0] cs_idle_level,
  input wire logic [`GP_PIN_COUNT-1:0] cs_active_level,
  input wire logic spi_active,
  input wire logic spi_cancel,
  input wire logic release_enable,
  input wire event_mode_e event_mode,
  input wire logic event_clear,
  input wire logic [`GP_PIN_COUNT-1:0] pin_in,
  output logic [`GP_PIN_COUNT-1:0] pin_out,
  output logic [`GP_PIN_COUNT-1:0] pin_oe_n,
  output logic [`GP_PIN_COUNT-1:0] pin_level,
  output logic [COUNT_WIDTH-1:0] event_count,
  output logic bus_released,
  output logic suspended
);
  localparam int IDLE_W = $clog2(IDLE_SUSPEND_CYCLES + 1);

  usb_state_e usb_state;
  usb_state_e resume_state;
  logic [IDLE_W-1:0] idle_count;
  logic [`GP_PIN_COUNT-1:0] gpio_dir;
  logic [`GP_PIN_COUNT-1:0] gpio_value;
  logic [`GP_PIN_COUNT-1:0] drive;
  logic [`GP_PIN_COUNT-1:0] drive_en;

  wire idle_timeout = (idle_count == IDLE_W'(IDLE_SUSPEND_CYCLES)); // see RULE_08
  wire enter_suspend = usb_events.suspend_seen | idle_timeout; // see RULE_06
  wire leave_suspend = usb_events.resume_seen | usb_events.bus_reset; // see RULE_07
  wire is_suspended = (usb_state == usb_suspended);
  wire is_configured = (usb_state == usb_configured);

  // dedicated roles; other pins never see these states, see RULE_18
  wire [`GP_PIN_COUNT-1:0] is_dedicated;
  wire request_pin_on = (pin_role[`GP_PIN_REQUEST] == role_dedicated);
  // active low request from the outside master, see RULE_17
  wire release_request = request_pin_on & ~pin_in[`GP_PIN_REQUEST] & release_enable; // see RULE_11
  wire next_released = release_request & (~spi_active | spi_cancel); // see RULE_15

  // traffic, suspend or a resume restarts the quiet window, see RULE_08
  wire idle_restart = usb_events.traffic | is_suspended | leave_suspend;
  // the count parks at the limit until something restarts it
  wire [IDLE_W-1:0] next_idle = idle_restart ? '0 :
                                idle_timeout ? idle_count : idle_count + IDLE_W'(1);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      idle_count <= '0;
    else
      idle_count <= next_idle;
  end

  usb_state_e next_state;
  usb_state_e next_resume;

  // bus reset wins over every other strobe, see RULE_07
  always_comb begin
    next_state = usb_state;
    next_resume = resume_state;
    if (usb_events.bus_reset) begin
      next_state = usb_unconfigured;
      next_resume = usb_unconfigured;
    end else begin
      unique case (usb_state)
        usb_suspended: begin
          // configured strobes are ignored while suspended
          if (leave_suspend) begin
            next_state = resume_state;
          end
        end
        usb_unconfigured,
        usb_configured: begin
          if (enter_suspend) begin
            // resume returns to where suspend found us, see RULE_06
            next_resume = usb_state;
            next_state = usb_suspended;
          end else if (usb_events.configured) begin
            next_state = usb_configured;
          end
        end
        default: begin
          next_state = usb_unconfigured;
        end
      endcase
    end
  end

  // device reset lands in unconfigured, which reads as resumed, see RULE_07
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      usb_state <= usb_unconfigured;
      resume_state <= usb_unconfigured;
    end else begin
      usb_state <= next_state;
      resume_state <= next_resume;
    end
  end

  // bus stays released while the request holds, released once safe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      bus_released <= 1'b0;
    else if (!release_request)
      bus_released <= 1'b0;
    else if (next_released)
      bus_released <= 1'b1;
  end

  // only pins already set as outputs take a strobe, see RULE_02
  wire [`GP_PIN_COUNT-1:0] gpio_take = gpio_write.write_strobe & gpio_dir;
  wire [`GP_PIN_COUNT-1:0] next_gpio_value = (gpio_value & ~gpio_take) |
                                             (gpio_write.out_value & gpio_take);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gpio_dir <= '0;
      gpio_value <= '0;
    end else begin
      gpio_dir <= gpio_write.dir_out;
      gpio_value <= next_gpio_value;
    end
  end

  // per-pin selection between gpio, chip select and dedicated drive
  genvar g;
  generate
    for (g = 0; g < `GP_PIN_COUNT; g++) begin : gen_pin
      wire sel_gpio = (pin_role[g] == role_gpio);
      wire sel_cs = (pin_role[g] == role_chip_select);
      logic fn_value;
      logic fn_drive;
      assign is_dedicated[g] = (pin_role[g] == role_dedicated);
      // pins 6 and 8 only listen in their dedicated role
      always_comb begin
        fn_value = 1'b1;
        fn_drive = 1'b0;
        if (g == `GP_PIN_SUSPEND) begin
          fn_value = ~is_suspended; // see RULE_04
          fn_drive = 1'b1;
        end else if (g == `GP_PIN_LED) begin
          fn_value = ~spi_active; // see RULE_13 see RULE_14
          fn_drive = 1'b1;
        end else if (g == `GP_PIN_LOW_POWER) begin
          fn_value = is_configured; // see RULE_09 see RULE_16
          fn_drive = 1'b1;
        end else if (g == `GP_PIN_CONFIGURED) begin
          fn_value = ~is_configured; // see RULE_05
          fn_drive = 1'b1;
        end else if (g == `GP_PIN_ACK) begin
          fn_value = ~bus_released; // see RULE_12
          fn_drive = 1'b1;
        end
      end
      wire next_value = sel_cs ? (spi_active ? cs_active_level[g] : cs_idle_level[g]) : // see RULE_03
                        sel_gpio ? gpio_value[g] : fn_value;
      // selects float while the bus is handed over
      wire next_en = sel_cs ? ~bus_released : sel_gpio ? gpio_dir[g] : fn_drive; // see RULE_01
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          drive[g] <= 1'b1;
          drive_en[g] <= 1'b0;
        end else begin
          drive[g] <= next_value;
          drive_en[g] <= next_en;
        end
      end
    end
  endgenerate

  assign pin_out = drive;
  assign pin_oe_n = ~drive_en;
  // read back the pad level of every pin, see RULE_02
  assign pin_level = pin_in;
  assign suspended = is_suspended;

  // counts only while pin 6 holds its event role, see RULE_10
  event_counter #(
    .WIDTH(COUNT_WIDTH)
  ) u_event_counter (
    .clk(clk),
    .reset_n(reset_n),
    .enable(is_dedicated[`GP_PIN_EVENT]),
    .mode(event_mode),
    .pin(pin_in[`GP_PIN_EVENT]),
    .clear(event_clear),
    .count(event_count)
  );
endmodule

// File: logic/gp_pin_consts.svh
/*
 gp_pin_consts.svh: pin numbers, counter width and timing counts for the
 general-purpose pin block. Assumes a 250 MHz device clock.
*/
`ifndef GP_PIN_CONSTS_SVH
`define GP_PIN_CONSTS_SVH
`define GP_PIN_COUNT 9
`define GP_PIN_SUSPEND 2
`define GP_PIN_LED 3
`define GP_PIN_LOW_POWER 4
`define GP_PIN_CONFIGURED 5
`define GP_PIN_EVENT 6
`define GP_PIN_ACK 7
`define GP_PIN_REQUEST 8
// nanoseconds keep the rounding sum inside a 32-bit int
`define CLK_PERIOD_NS 4
`define IDLE_SUSPEND_NS 3000000
`define IDLE_SUSPEND_CYCLES ((`IDLE_SUSPEND_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define EVENT_COUNT_WIDTH 16
`endif

// File: logic/gp_pin_pkg.sv
/*
 gp_pin_pkg.sv: types shared by the general-purpose pin block.
 Assumes gp_pin_consts.svh is on the include path.
*/
`include "gp_pin_consts.svh"
package gp_pin_pkg;
  // per-pin role; dedicated is honoured only on pins that own a function
  typedef enum logic [1:0] {
    role_gpio,
    role_chip_select,
    role_dedicated
  } pin_role_e;

  typedef enum logic [1:0] {
    edge_falling,
    edge_rising,
    pulse_low,
    pulse_high
  } event_mode_e;

  typedef enum logic [1:0] {
    usb_unconfigured,
    usb_configured,
    usb_suspended
  } usb_state_e;

  // usb core event strobes, one cycle each
  typedef struct packed {
    logic suspend_seen;
    logic resume_seen;
    logic bus_reset;
    logic configured;
    logic traffic;
  } usb_events_s;

  typedef struct packed {
    logic [`GP_PIN_COUNT-1:0] dir_out;
    logic [`GP_PIN_COUNT-1:0] out_value;
    logic [`GP_PIN_COUNT-1:0] write_strobe;
  } gpio_write_s;
endpackage

// File: logic/event_counter.sv
/*
 event_counter.sv: counts qualifying events on one sampled pin.
 Assumes the pin is synchronous to clk.
*/
`timescale 1ns/1ps
`include "gp_pin_consts.svh"
module event_counter
  import gp_pin_pkg::*;
#(
  parameter int WIDTH = `EVENT_COUNT_WIDTH
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic enable,
  input wire event_mode_e mode,
  input wire logic pin,
  input wire logic clear,
  output logic [WIDTH-1:0] count
);
  logic last;
  wire rise = pin & ~last;
  wire fall = ~pin & last;
  // a pulse counts when it ends, so its width is complete
  wire hit = (mode == edge_falling) ? fall :
             (mode == edge_rising) ? rise :
             (mode == pulse_low) ? rise : fall;
  wire [WIDTH-1:0] next_count = count + WIDTH'(1);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      last <= 1'b1;
      count <= '0;
    end else begin
      last <= pin;
      if (clear)
        count <= (enable && hit) ? WIDTH'(1) : '0;
      else if (enable && hit)
        count <= next_count; // see RULE_10
    end
  end
endmodule

// File: verif/gp_pin_props.sv
/* checker for gp_pin_function_status port timing.
   bound to the design; sees only its top ports. */
`timescale 1ns/1ps
module gp_pin_props
  import gp_pin_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire pin_role_e [8:0] pin_role,
  input wire usb_events_s usb_events,
  input wire logic spi_active,
  input wire logic spi_cancel,
  input wire logic release_enable,
  input wire logic [8:0] pin_in,
  input wire logic [8:0] pin_out,
  input wire logic [8:0] pin_oe_n,
  input wire logic [8:0] pin_level,
  input wire logic bus_released,
  input wire logic suspended
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire req = !pin_in[8] && pin_role[8] == role_dedicated && release_enable;
  wire go = !spi_active || spi_cancel;
  property p_level; pin_level == pin_in; endproperty
  a_level: assert property (p_level) else $error("level");
  property p_led; $past(reset_n) && $past(pin_role[3]) == role_dedicated
    |-> {pin_out[3], pin_oe_n[3]} == {!$past(spi_active), 1'b0}; endproperty
  a_led: assert property (p_led) else $error("led");
  property p_suspend_indicator; $past(pin_role[2]) == role_dedicated
    |-> pin_out[2] == !$past(suspended); endproperty
  a_suspend_indicator: assert property (p_suspend_indicator) else $error("suspend pin");
  property p_ack; $past(pin_role[7]) == role_dedicated
    |-> pin_out[7] == !$past(bus_released); endproperty
  a_ack: assert property (p_ack) else $error("ack pin");
  property p_enter; usb_events.suspend_seen && !usb_events.bus_reset
    && !usb_events.resume_seen |=> suspended; endproperty
  a_enter: assert property (p_enter) else $error("no suspend");
  property p_leave; suspended && (usb_events.resume_seen || usb_events.bus_reset)
    |=> !suspended; endproperty
  a_leave: assert property (p_leave) else $error("no resume");
  property p_grant; req && go |=> bus_released; endproperty
  a_grant: assert property (p_grant) else $error("no release");
  property p_hold; req && !go && !bus_released |=> !bus_released; endproperty
  a_hold: assert property (p_hold) else $error("early release");
  c_rel: cover property ($rose(bus_released));
  c_susp: cover property ($rose(suspended));
  c_wait: cover property (req && !go);
endmodule
bind gp_pin_function_status gp_pin_props u_gp_pin_props (.clk, .reset_n, .pin_role,
  .usb_events, .spi_active, .spi_cancel, .release_enable, .pin_in, .pin_out,
  .pin_oe_n, .pin_level, .bus_released, .suspended);

// File: verif/gp_far_side.sv
/* pads and external parties beyond the nine pins.
   driven pads read back the block's value; others take ext, and pin 8 the inverse of bus_want. */
`timescale 1ns/1ps
module gp_far_side (
  input wire logic [8:0] pin_out,
  input wire logic [8:0] pin_oe_n,
  input wire logic [7:0] ext,
  input wire logic bus_want,
  output logic [8:0] pin_in
);
  wire [8:0] far = {!bus_want, ext};
  assign pin_in = (pin_out & ~pin_oe_n) | (far & pin_oe_n);
endmodule

// File: verif/gp_pin_function_status_tb.sv
/* self-checking bench for gp_pin_function_status with a pad model.
   short idle count; inputs move on the falling clock edge. */
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module gp_pin_function_status_tb
  import gp_pin_pkg::*;
;
  localparam int IDLE = 20;
  logic clk = 0, reset_n = 0, spi_active = 0, spi_cancel = 0, rel_en = 0, clr = 0, want = 0;
  pin_role_e [8:0] role;
  gpio_write_s gw = '0;
  usb_events_s ev = '0;
  event_mode_e mode = edge_rising;
  logic [8:0] csi = 9'h1FF, csa = 9'h000, pin_in, pin_out, oe_n, lvl;
  logic [7:0] ext = 8'hFF;
  logic [15:0] cnt;
  logic rel, susp;
  int err_count = 0, n_tests = 0, cyc = 0;
  always #2 clk = ~clk;
  gp_pin_function_status #(.IDLE_SUSPEND_CYCLES(IDLE)) u_gp_pin_function_status (
    .clk, .reset_n, .pin_role(role), .gpio_write(gw), .usb_events(ev),
    .cs_idle_level(csi), .cs_active_level(csa), .spi_active, .spi_cancel,
    .release_enable(rel_en), .event_mode(mode), .event_clear(clr), .pin_in,
    .pin_out, .pin_oe_n(oe_n), .pin_level(lvl), .event_count(cnt),
    .bus_released(rel), .suspended(susp));
  gp_far_side u_gp_far_side (.pin_out, .pin_oe_n(oe_n), .ext, .bus_want(want), .pin_in);
  task automatic w(int n); repeat (n) @(negedge clk); endtask
  // traffic held on so the idle timer stays quiet outside its own test
  task automatic usb(logic [4:0] e); ev = e | 5'h01; w(1); ev = 5'h01; w(2); endtask
  task automatic t_usb;
    `CHK({pin_out[5:4], pin_out[2]}, 3'b101)
    usb(5'h02);
    `CHK(pin_out[5:4], 2'b01)
    usb(5'h10);
    `CHK({susp, pin_out[5:4], pin_out[2], oe_n[0]}, 5'b11001)
    usb(5'h08);
    `CHK({susp, pin_out[5:4], pin_out[2]}, 4'b0011)
    usb(5'h10);
    usb(5'h04);
    `CHK({susp, pin_out[2]}, 2'b01)
  endtask
  task automatic t_idle;
    ev = '0;
    w(IDLE);
    `CHK(susp, 1'b0)
    w(1);
    `CHK(susp, 1'b1)
    usb(5'h08);
  endtask
  task automatic t_spi;
    spi_active = 1;
    w(2);
    `CHK({pin_out[3], oe_n[3], pin_out[1], oe_n[1]}, {2'b00, csa[1], 1'b0})
    spi_active = 0;
    w(2);
    `CHK({pin_out[3], pin_out[1]}, {1'b1, csi[1]})
  endtask
  task automatic t_rel;
    {rel_en, spi_active, want} = 3'b111;
    w(3);
    `CHK({rel, pin_out[7]}, 2'b01)
    spi_active = 0;
    w(3);
    `CHK({rel, pin_out[7], oe_n[1]}, 3'b101)
    want = 0;
    w(3);
    `CHK({rel, pin_out[7]}, 2'b01)
    {spi_active, spi_cancel, want} = 3'b111;
    w(3);
    `CHK(rel, 1'b1)
    {spi_active, spi_cancel, want} = 3'b000;
    w(3);
  endtask
  task automatic t_gpio;
    gw = '{9'h001, 9'h000, 9'h000};
    w(1);
    gw.write_strobe = 9'h001;
    w(1);
    gw.write_strobe = 9'h000;
    w(2);
    `CHK({pin_out[0], oe_n[0], lvl[0]}, 3'b000)
    gw = '{9'h000, 9'h001, 9'h000};
    w(2);
    gw.write_strobe = 9'h001;
    w(1);
    gw.write_strobe = 9'h000;
    w(2);
    `CHK({oe_n[0], lvl[0]}, 2'b11)
    gw.dir_out = 9'h001;
    w(2);
    `CHK(pin_out[0], 1'b0)
    gw.write_strobe = 9'h001;
    w(1);
    gw.write_strobe = 9'h000;
    w(2);
    `CHK({pin_out[0], oe_n[0], lvl[0]}, 3'b101)
    role[5] = role_gpio;
    gw.dir_out = 9'h021;
    w(2);
    usb(5'h10);
    `CHK({susp, pin_out[5], oe_n[5]}, 3'b100)
    usb(5'h08);
    role[5] = role_dedicated;
  endtask
  task automatic t_evt;
    for (int m = 0; m < 4; m++) begin
      mode = event_mode_e'(m);
      clr = 1;
      w(1);
      clr = 0;
      // fall, rise, fall: the two edge directions count apart
      for (int k = 0; k < 3; k++) begin
        ext[6] = ~ext[6];
        w(2);
      end
      `CHK(cnt, (m == 0 || m == 3) ? 16'h0002 : 16'h0001)
      ext[6] = ~ext[6];
      w(2);
    end
  endtask
  task automatic give_verdict;
    if (err_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      give_verdict;
    end
  end
  initial begin
    for (int i = 0; i < 9; i++) role[i] = i < 2 ? pin_role_e'(i) : role_dedicated;
    w(20);
    reset_n = 1;
    ev = 5'h01;
    w(3);
    t_usb;
    t_idle;
    t_spi;
    t_rel;
    t_gpio;
    t_evt;
    give_verdict;
  end
endmodule
